//--- logic/ipw_pkg.sv
// Package for the interrupt priority and wake controller.
// Assumes one 125 MHz clock domain and an AHB-Lite register port.
package ipw_pkg;
	// ==========================================================
	// Register map: word index, byte address is four times the index
	localparam logic [7:0] OFF_PRIO_0     = 8'h32;
	localparam logic [7:0] OFF_PRIO_1     = 8'h33;
	localparam logic [7:0] OFF_PRIO_2     = 8'h34;
	localparam logic [7:0] OFF_PRIO_3     = 8'h35;
	localparam logic [7:0] OFF_EXT_CFG_1  = 8'h08;
	localparam logic [7:0] OFF_EXT_CFG_2  = 8'h39;
	localparam logic [7:0] OFF_MISC       = 8'h40;
	localparam logic [7:0] OFF_STATUS     = 8'h44;
	localparam logic [7:0] OFF_PENDING    = 8'h48;
	localparam logic [7:0] OFF_CPU_CTRL   = 8'h4c;
	// ==========================================================
	// Reset values and field positions
	localparam logic [7:0] PRIO_RST       = 8'hff;
	localparam logic [7:0] EXT_CFG_RST    = 8'h00;
	localparam logic [2:0] SLOW_DIV_RST   = 3'h0;
	localparam int         SENSE_LSB      = 4;
	localparam int         NUM_VEC        = 11;
	// ==========================================================
	// Vector addresses (low byte of pair)
	localparam logic [15:0] VEC_RESET     = 16'hfffe;
	localparam logic [15:0] VEC_BASE      = 16'hfffa;
	// ==========================================================
	// Sensitivity encodings
	localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] SENSE_RISE     = 2'h1;
	localparam logic [1:0] SENSE_FALL     = 2'h2;
	localparam logic [1:0] SENSE_BOTH     = 2'h3;
	// Vectors able to leave halt: 0..4
	localparam logic [10:0] HALT_WAKE_MASK = 11'h01f;
	// ==========================================================
	// Timing
	localparam int WAKE_STAB_CYC = 514;
	localparam int MCLK_MUL      = 2;
	localparam int MCLK_DIV      = 3;
	typedef enum logic [3:0] {
		IPW_RUN  = 4'b0001,
		IPW_WAIT = 4'b0010,
		IPW_HALT = 4'b0100,
		IPW_STAB = 4'b1000
	} ipw_mode_e;
endpackage

//--- logic/ipw_ctrl.sv
// Interrupt vectoring, priority storage, external line sense and power modes.
// Assumes core gives instr strobes and an ack when it enters a service routine.
// Operation
// - Pair sense field: fall+low, rise, fall, both
// - Lines 10 and 9 share one sensitivity
// - Config2 low bits enable lines 12..9
// - Programming start is vector 0, wakes halt
// - USB end-suspend is vector 1, wakes halt
// - Lines 4..1 share vector 2, wake halt
// - Lines 8..5 share vector 3, wake halt
// - Lines 12..9 share vector 4, wake halt
// - USB general is vector 9, no wake
// - Converter done is vector 10, lowest, no wake
// - Four priority registers, reset all ones
// - Slow divider bits slow the clock enable
// - Run clock is oscillator times two thirds
// - Wait stops core, peripherals keep running
// - Wait entry forces mask bit to zero
// - Wait ends on any interrupt or reset
// - Halt stops oscillator and all peripherals
// - Halt entry clears the mask bit
// - Only wake-capable requests leave halt
// - Wake holds core 514 clock cycles
// - After delay service the waking interrupt
// - Serve only if enabled and priority higher, or at any priority in wait mode
// - Writing level-0 pattern keeps old pair
// - Edge requests latched, cleared on entry
module ipw_ctrl
	import ipw_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// External lines 12..1 (pins)
	input  wire logic [11:0] ext_line_pin,
	// Peripheral request levels
	input  wire logic        icp_req,
	input  wire logic        usb_susp_end_req,
	input  wire logic        tbu_req,
	input  wire logic        art_req,
	input  wire logic        spi_req,
	input  wire logic        sci_req,
	input  wire logic        usb_gen_req,
	input  wire logic        adc_req,
	// Core handshake
	input  wire logic        wait_for_irq_instr,
	input  wire logic        halt_instr,
	input  wire logic        irq_ack,
	input  wire logic [1:0]  cur_level,
	// Core side outputs
	output logic             irq_valid,
	output logic      [3:0]  irq_num,
	output logic      [15:0] irq_vector,
	output logic      [1:0]  irq_level,
	output logic             core_run,
	output logic             periph_run,
	output logic             osc_on,
	output logic             clear_imask,
	output logic             clk_en
);
	import ipw_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0]  prio_q [4];
	logic [7:0]  cfg1_q;
	logic [7:0]  cfg2_q;
	logic [2:0]  slow_div_q;
	ipw_mode_e   mode_q;
	logic [9:0]  stab_q;
	logic [10:0] pend_q;

	// ==========================================================
	// AHB-Lite slave: zero wait states
	logic       wr_ph_q;
	logic [7:0] wa_q;
	logic       acc;
	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q <= 1'b0;
			wa_q    <= 8'h00;
		end else if (hready) begin
			wr_ph_q <= acc && hwrite;
			wa_q    <= haddr[9:2];
		end
	end

	function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] nw);
		logic [7:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (nw[2*i +: 2] != 2'b10)
				r[2*i +: 2] = nw[2*i +: 2];
		end
		return r;
	endfunction

	// Merged value for the register with read-only top bits
	logic [7:0] prio3_mg;
	assign prio3_mg = prio_merge(prio_q[3], hwdata[7:0]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++)
				prio_q[i] <= PRIO_RST;
			cfg1_q     <= EXT_CFG_RST;
			cfg2_q     <= EXT_CFG_RST;
			slow_div_q <= SLOW_DIV_RST;
		end else if (wr_ph_q) begin
			unique case (wa_q)
				OFF_PRIO_0:    prio_q[0] <= prio_merge(prio_q[0], hwdata[7:0]);
				OFF_PRIO_1:    prio_q[1] <= prio_merge(prio_q[1], hwdata[7:0]);
				OFF_PRIO_2:    prio_q[2] <= prio_merge(prio_q[2], hwdata[7:0]);
				OFF_PRIO_3:    prio_q[3] <= {4'hf, prio3_mg[3:0]};
				OFF_EXT_CFG_1: cfg1_q <= hwdata[7:0];
				OFF_EXT_CFG_2: cfg2_q <= hwdata[7:0];
				OFF_MISC:      slow_div_q <= hwdata[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (acc && !hwrite) begin
			unique case (haddr[9:2])
				OFF_PRIO_0:    hrdata <= {24'h0, prio_q[0]};
				OFF_PRIO_1:    hrdata <= {24'h0, prio_q[1]};
				OFF_PRIO_2:    hrdata <= {24'h0, prio_q[2]};
				OFF_PRIO_3:    hrdata <= {24'h0, prio_q[3]};
				OFF_EXT_CFG_1: hrdata <= {24'h0, cfg1_q};
				OFF_EXT_CFG_2: hrdata <= {24'h0, cfg2_q};
				OFF_MISC:      hrdata <= {29'h0, slow_div_q};
				OFF_STATUS:    hrdata <= {28'h0, mode_q};
				OFF_PENDING:   hrdata <= {21'h0, pend_q};
				default:       hrdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ==========================================================
	// Pin synchronisers: three stages, change accepted when 2 and 3 agree
	logic [11:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q       <= 12'hfff;
			s2_q       <= 12'hfff;
			s3_q       <= 12'hfff;
			lvl_q      <= 12'hfff;
			lvl_prev_q <= 12'hfff;
		end else begin
			s1_q       <= ext_line_pin;
			s2_q       <= s1_q;
			s3_q       <= s2_q;
			lvl_q      <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
			lvl_prev_q <= lvl_q;
		end
	end

	// ==========================================================
	// External line sensing
	logic [11:0] rise, fall, hit;
	logic [11:0] line_en;
	logic [1:0]  pair_sense;
	logic [1:0]  hi_sense;
	logic        low_lvl_c, low_lvl_d;
	assign rise       = lvl_q & ~lvl_prev_q;
	assign fall       = ~lvl_q & lvl_prev_q;
	assign line_en    = {cfg2_q[3:0], cfg1_q};
	assign pair_sense = cfg2_q[SENSE_LSB +: 2];
	assign hi_sense   = cfg2_q[7:6];

	function automatic logic sense_hit(input logic [1:0] s, input logic r, input logic f);
		unique case (s)
			SENSE_FALL_LOW: return f;
			SENSE_RISE:     return r;
			SENSE_FALL:     return f;
			SENSE_BOTH:     return r | f;
		endcase
	endfunction

	always_comb begin
		for (int i = 0; i < 12; i++)
			hit[i] = line_en[i] & fall[i];
		for (int i = 4; i < 6; i++)
			hit[i] = line_en[i] & rise[i];
		for (int i = 8; i < 10; i++)
			hit[i] = line_en[i] & sense_hit(pair_sense, rise[i], fall[i]);
		for (int i = 10; i < 12; i++)
			hit[i] = line_en[i] & sense_hit(hi_sense, rise[i], fall[i]);
	end
	// Low level hold for the falling+low setting of port C
	assign low_lvl_c = (pair_sense == SENSE_FALL_LOW) && |(line_en[9:8] & ~lvl_q[9:8]);
	assign low_lvl_d = (hi_sense == SENSE_FALL_LOW) && |(line_en[11:10] & ~lvl_q[11:10]);

	// ==========================================================
	// Pending latches; set beats clear
	logic [10:0] set_v;
	logic [10:0] ack_v;
	always_comb begin
		set_v     = '0;
		set_v[0]  = icp_req;
		set_v[1]  = usb_susp_end_req;
		set_v[2]  = |hit[3:0];
		set_v[3]  = |hit[7:4];
		set_v[4]  = |hit[11:8] | low_lvl_c | low_lvl_d;
		set_v[5]  = tbu_req;
		set_v[6]  = art_req;
		set_v[7]  = spi_req;
		set_v[8]  = sci_req;
		set_v[9]  = usb_gen_req;
		set_v[10] = adc_req;
		ack_v     = '0;
		if (irq_ack && irq_valid && irq_num < 4'(NUM_VEC))
			ack_v[irq_num] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend_q <= '0;
		else
			pend_q <= set_v | (pend_q & ~ack_v);
	end

	// ==========================================================
	// Arbitration
	function automatic logic [1:0] rank(input logic [1:0] p);
		unique case (p)
			2'b10: return 2'h0;
			2'b01: return 2'h1;
			2'b00: return 2'h2;
			2'b11: return 2'h3;
		endcase
	endfunction

	logic [87:0] prio_flat;
	logic [10:0] elig;
	logic        win_v;
	logic [3:0]  win_n;
	logic [1:0]  win_r;
	assign prio_flat = {prio_q[2], prio_q[1], prio_q[0], prio_q[3], prio_q[2], prio_q[1], prio_q[0], 8'h00};
	always_comb begin
		win_v = 1'b0;
		win_n = 4'h0;
		win_r = 2'h0;
		for (int v = 0; v < NUM_VEC; v++) begin
			elig[v] = pend_q[v] && (rank(prio_flat[8 + 2*v +: 2]) > rank(cur_level) || mode_q != IPW_RUN);
			if (mode_q == IPW_HALT || mode_q == IPW_STAB)
				elig[v] = elig[v] && HALT_WAKE_MASK[v];
			if (elig[v] && (!win_v || rank(prio_flat[8 + 2*v +: 2]) > win_r)) begin
				win_v = 1'b1;
				win_n = 4'(v);
				win_r = rank(prio_flat[8 + 2*v +: 2]);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_valid  <= 1'b0;
			irq_num    <= 4'h0;
			irq_vector <= VEC_RESET;
			irq_level  <= 2'h3;
		end else begin
			irq_valid  <= win_v && (mode_q == IPW_RUN || mode_q == IPW_WAIT) && !(irq_ack && irq_valid);
			irq_num    <= win_n;
			irq_vector <= VEC_BASE - {11'h0, win_n, 1'b0};
			irq_level  <= prio_flat[8 + 2*win_n +: 2];
		end
	end

	// ==========================================================
	// Power mode machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q      <= IPW_RUN;
			stab_q      <= '0;
			clear_imask <= 1'b0;
		end else begin
			clear_imask <= 1'b0;
			unique case (mode_q)
				IPW_RUN: begin
					if (halt_instr) begin
						mode_q      <= IPW_HALT;
						clear_imask <= 1'b1;
					end else if (wait_for_irq_instr) begin
						mode_q      <= IPW_WAIT;
						clear_imask <= 1'b1;
					end
				end
				IPW_WAIT: if (|pend_q) mode_q <= IPW_RUN;
				IPW_HALT: begin
					if (|(pend_q & HALT_WAKE_MASK)) begin
						mode_q <= IPW_STAB;
						stab_q <= 10'(WAKE_STAB_CYC - 1);
					end
				end
				IPW_STAB: begin
					if (clk_en) begin
						if (stab_q == '0)
							mode_q <= IPW_RUN;
						else
							stab_q <= stab_q - 10'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_run   <= 1'b1;
			periph_run <= 1'b1;
			osc_on     <= 1'b1;
		end else begin
			core_run   <= (mode_q == IPW_RUN) && !halt_instr && !wait_for_irq_instr;
			periph_run <= mode_q == IPW_RUN || mode_q == IPW_WAIT;
			osc_on     <= mode_q != IPW_HALT;
		end
	end

	// ==========================================================
	// Master clock enable: 2 of every 3 cycles, slowed by the divider
	logic [1:0] ph_q;
	logic [2:0] sd_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q   <= 2'h0;
			sd_q   <= 3'h0;
			clk_en <= 1'b0;
		end else begin
			ph_q   <= (ph_q == 2'(MCLK_DIV - 1)) ? 2'h0 : ph_q + 2'h1;
			if (ph_q < 2'(MCLK_MUL)) begin
				sd_q   <= (sd_q >= slow_div_q) ? 3'h0 : sd_q + 3'h1;
				clk_en <= (sd_q >= slow_div_q);
			end else
				clk_en <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	a_level0_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ph_q && wa_q == OFF_PRIO_0 && hwdata[1:0] == 2'b10 |=> $stable(prio_q[0][1:0]))
		else $error("level 0 pattern stored");
	a_halt_no_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == IPW_HALT && !(|(pend_q & HALT_WAKE_MASK)) |=> mode_q == IPW_HALT)
		else $error("halt left without wake request");
	a_stab_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(mode_q == IPW_STAB) |-> !core_run [*8])
		else $error("core ran during stabilisation");
	a_halt_enter: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == IPW_RUN && halt_instr |=> mode_q == IPW_HALT && clear_imask)
		else $error("halt entry wrong");
	a_wait_enter: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == IPW_RUN && !halt_instr && wait_for_irq_instr |=> mode_q == IPW_WAIT && clear_imask)
		else $error("wait entry wrong");
	a_wait_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == IPW_WAIT && |pend_q |=> mode_q == IPW_RUN)
		else $error("wait not left");
	a_ack_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_ack && irq_valid && !set_v[irq_num] |=> !pend_q[$past(irq_num)])
		else $error("pending not cleared on entry");
	a_prio3_top: assert property (@(posedge hclk) disable iff (!hresetn)
		prio_q[3][7:4] == 4'hf)
		else $error("read-only bits changed");
	a_no_low_vec: assert property (@(posedge hclk) disable iff (!hresetn)
		win_v && win_n == 4'ha && prio_q[2][3:2] == prio_q[2][5:4] |-> !elig[9])
		else $error("adc chosen over equal usb");
	c_wake_halt: cover property (@(posedge hclk) disable iff (!hresetn) mode_q == IPW_STAB ##1 mode_q == IPW_RUN);
	c_wait_irq:  cover property (@(posedge hclk) disable iff (!hresetn) mode_q == IPW_WAIT ##1 mode_q == IPW_RUN);
	c_serviced:  cover property (@(posedge hclk) disable iff (!hresetn) irq_valid && irq_ack);
endmodule

//--- tb/ipw_core_model.sv
// Core model: acks each presented vector and logs it.
// Assumes the ack contract of the controller.
module ipw_core_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Controller side
	input  wire logic       irq_valid,
	input  wire logic [3:0] irq_num,
	input  wire logic       core_run,
	input  wire logic [3:0] ack_dly,
	output logic            irq_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int         cnt [16];
	int         w;
	logic [3:0] log_q [$];
	// ====
	// Acks only a running core, after a delay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ack <= 1'b0;
			w = 0;
		end else begin
			irq_ack <= 1'b0;
			if (irq_valid === 1'b1 && core_run === 1'b1 && !irq_ack) begin
				if (w >= ack_dly) begin
					irq_ack <= 1'b1;
					cnt[irq_num]++;
					log_q.push_back(irq_num);
					w = 0;
				end else begin
					w++;
				end
			end
		end
	end
endmodule

//--- tb/irq_priority_and_wake_ctrl_tb_top.sv
// Bench for the priority and wake controller.
// Assumes the core model acks vectors; bus is one AHB-Lite master.
module irq_priority_and_wake_ctrl_tb_top;
	import ipw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [11:0] pin = 12'hfff;
	logic [12:0] rq = 13'h0;
	logic [1:0]  lvl = 2'h2;
	logic [3:0]  ad = 4'h0;
	logic        ack, irq_valid, core_run, periph_run, osc_on, clk_en;
	logic [3:0]  irq_num;
	logic [15:0] irq_vector;
	logic [1:0]  irq_lv;
	logic        imask_clr, pe;
	int          clr_cnt = 0;
	int          vl [8] = '{0, 1, 5, 6, 7, 8, 9, 10};
	int          err_total = 0;
	int          checked = 0;
	int          seed = 18033;
	int          cyc = 0;
	int          i, s, b, n;
	logic [7:0]  sh [4];
	logic [31:0] t;
	always #4 hclk = ~hclk;
	ipw_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_line_pin(pin), .icp_req(rq[0]),
		.usb_susp_end_req(rq[1]), .tbu_req(rq[5]), .art_req(rq[6]), .spi_req(rq[7]),
		.sci_req(rq[8]), .usb_gen_req(rq[9]), .adc_req(rq[10]), .wait_for_irq_instr(rq[11]),
		.halt_instr(rq[12]), .irq_ack(ack), .cur_level(lvl), .irq_valid(irq_valid),
		.irq_num(irq_num), .irq_vector(irq_vector), .irq_level(irq_lv), .core_run(core_run),
		.periph_run(periph_run), .osc_on(osc_on), .clear_imask(imask_clr), .clk_en(clk_en));
	ipw_core_model u_core (.hclk(hclk), .hresetn(hresetn), .irq_valid(irq_valid), .irq_num(irq_num),
		.core_run(core_run), .ack_dly(ad), .irq_ack(ack));
	// ====
	// Checks and expectations
	task automatic test_done();
		$display("Counts: checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_prio(input logic [7:0] o, input logic [7:0] w, input logic top);
		for (int k = 0; k < 4; k++) begin
			if (w[2*k+:2] != 2'b10) o[2*k+:2] = w[2*k+:2];
		end
		if (top) o[7:4] = 4'hf;
		return o;
	endfunction
	always @(posedge hclk) begin
		if (imask_clr === 1'b1) clr_cnt++;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			test_done();
		end
	end
	// ====
	// Drivers
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {22'h0, a, 2'b00};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	task automatic pulse(input logic [12:0] m);
		@(posedge hclk);
		rq <= m;
		@(posedge hclk);
		rq <= 13'h0;
	endtask
	task automatic nxt(input int v);
		int k;
		k = 0;
		ad <= 4'($random(seed) & 7);
		while (irq_valid !== 1'b1 && k < 2000) begin
			@(negedge hclk);
			k++;
		end
		chk({28'h0, irq_num}, v);
		chk({16'h0, irq_vector}, 32'hfffa - 2 * v);
		chk({30'h0, irq_lv}, {30'h0, sh[v / 4][2 * (v % 4) +: 2]});
		while (irq_valid === 1'b1 && k < 2000) begin
			@(negedge hclk);
			k++;
		end
	endtask
	task automatic edge_chk(input int bit_i, input logic val, input int e);
		int v, c;
		v = (bit_i < 4) ? 2 : (bit_i < 8) ? 3 : 4;
		c = u_core.cnt[v];
		@(posedge hclk);
		pin[bit_i] <= val;
		repeat (40) @(posedge hclk);
		if (e != 2) chk(u_core.cnt[v] != c, e);
	endtask
	task automatic count_en(output int m);
		m = 0;
		repeat (300) begin
			@(negedge hclk);
			if (clk_en === 1'b1) m++;
		end
	endtask
	// ====
	// Main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 4; i++) rdc(OFF_PRIO_0 + 8'(i), 32'hff);
		rdc(OFF_EXT_CFG_2, 32'h0);
		rdc(8'h3c, 32'h0);
		chk(hresp, 1'b0);
		for (i = 0; i < 4; i++) sh[i] = 8'hff;
		repeat (12) begin
			s = $random(seed) & 3;
			t = $random(seed);
			wr(OFF_PRIO_0 + 8'(s), t);
			sh[s] = exp_prio(sh[s], t[7:0], s == 3);
			rdc(OFF_PRIO_0 + 8'(s), {24'h0, sh[s]});
		end
		wr(OFF_PRIO_0, 32'hcf);
		wr(OFF_PRIO_0, 32'h64);
		rdc(OFF_PRIO_0, 32'h44);
		for (i = 0; i < 4; i++) begin
			wr(OFF_PRIO_0 + 8'(i), 32'hff);
			sh[i] = 8'hff;
		end
		count_en(n);
		chk(n, 200);
		wr(OFF_MISC, 32'h1);
		count_en(n);
		chk(n < 200 && n > 0, 1'b1);
		wr(OFF_MISC, 32'h0);
		foreach (vl[j]) begin
			n = vl[j];
			pulse(13'(1 << n));
			nxt(n);
		end
		pulse(13'h600);
		nxt(9);
		nxt(10);
		wr(OFF_PRIO_2, 32'hf7);
		sh[2] = 8'hf7;
		pulse(13'h600);
		nxt(10);
		nxt(9);
		lvl <= 2'h3;
		pulse(13'h400);
		repeat (30) @(negedge hclk);
		chk(irq_valid, 1'b0);
		lvl <= 2'h2;
		nxt(10);
		wr(OFF_EXT_CFG_1, 32'hff);
		pin[0] <= 1'b0;
		nxt(2);
		pin[0] <= 1'b1;
		edge_chk(4, 1'b0, 0);
		pin[4] <= 1'b1;
		nxt(3);
		for (s = 0; s < 4; s++) begin
			wr(OFF_EXT_CFG_2, {26'h0, s[1:0], 4'hf});
			for (b = 8; b < 10; b++) begin
				edge_chk(b, 1'b0, s != 1);
				edge_chk(b, 1'b1, s == 0 ? 2 : s[0]);
			end
		end
		wr(OFF_EXT_CFG_2, 32'h30);
		edge_chk(8, 1'b0, 0);
		edge_chk(8, 1'b1, 0);
		wr(OFF_EXT_CFG_2, 32'h2f);
		pin[8] <= 1'b0;
		nxt(4);
		pin[8] <= 1'b1;
		lvl <= 2'h3;
		n = clr_cnt;
		pulse(13'h800);
		repeat (3) @(negedge hclk);
		chk({core_run, periph_run}, 2'b01);
		chk(clr_cnt - n, 1);
		// Core obeys the mask clear: level drops to 0
		lvl <= 2'b10;
		pulse(13'h400);
		nxt(10);
		lvl <= 2'h2;
		n = clr_cnt;
		pulse(13'h1000);
		repeat (3) @(negedge hclk);
		chk({core_run, periph_run, osc_on}, 3'b000);
		chk(clr_cnt - n, 1);
		pulse(13'h420);
		repeat (60) @(negedge hclk);
		chk(osc_on, 1'b0);
		pulse(13'h1);
		n = 0;
		i = 0;
		pe = 1'b0;
		// Enable pulse of edge m counts when osc is up and core still held after m
		while (core_run !== 1'b1 && i < 3000) begin
			@(negedge hclk);
			i++;
			if (pe && osc_on === 1'b1 && core_run !== 1'b1) n++;
			pe = (clk_en === 1'b1);
		end
		chk(n, 514);
		nxt(0);
		nxt(5);
		nxt(10);
		test_done();
	end
endmodule
